// ==== bench/enc_partner.sv ====
// downstream encoder stand-in: accepts bytes, stalls at random when asked
module enc_partner (
  input wire logic clk,
  input wire logic resetn,
  input wire logic stall_en,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rnd_q;
  function automatic logic [31:0] step(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // ready low about one cycle in sixteen while stalls are on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rnd_q <= 32'h000166a9;
      out_ready <= 1'b0;
    end else begin
      rnd_q <= step(rnd_q);
      out_ready <= !(stall_en && rnd_q[3:0] == 4'h0);
    end
  end
endmodule

// ==== bench/test_recording_mgmt_sector_builder.sv ====
module test_recording_mgmt_sector_builder
  import rm_sector_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, resetn, reg_wr, reg_rd, out_valid, out_ready, out_last, region_done;
  logic stall_en, chk_on, hold_q;
  logic [7:0] reg_addr, disc_state, app_code, phys_code, power_tuning_code, wavelength_code;
  logic [7:0] out_byte;
  logic [31:0] reg_wdata, reg_rdata, strategy_code, rnd;
  logic [255:0] maker_str;
  logic [127:0] serial_str, model_str;
  logic [143:0] disc_id, maker_seg;
  logic [23:0] last_data_addr, out_block, tgt;
  logic [15:0] byte_position, exp_pos, held_pos;
  int n_mismatch, num_checks, n_hs, n_done, w;

  recording_mgmt_sector_builder recording_mgmt_sector_builder_inst (.clk(clk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .maker_str(maker_str), .serial_str(serial_str),
    .model_str(model_str), .disc_id(disc_id), .disc_state(disc_state), .app_code(app_code),
    .phys_code(phys_code), .last_data_addr(last_data_addr),
    .power_tuning_code(power_tuning_code), .wavelength_code(wavelength_code),
    .strategy_code(strategy_code), .maker_seg(maker_seg), .out_valid(out_valid),
    .out_ready(out_ready), .out_byte(out_byte), .byte_position(byte_position),
    .out_block(out_block), .out_last(out_last), .region_done(region_done));
  enc_partner enc_partner_inst (.clk(clk), .resetn(resetn), .stall_en(stall_en),
    .out_ready(out_ready));

  always #20 clk = ~clk;

  function automatic logic [31:0] next_rnd();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction

  // expected stream byte at a region position
  function automatic logic [7:0] exp_byte(input logic [15:0] p);
    int i;
    i = p[10:0];
    if (p < 16'h4000) return 8'h00;
    if (p < 16'h8000) begin
      if (i <= 31) return maker_str[8*i+:8];
      if (i >= 40 && i <= 55) return serial_str[8*(i-40)+:8];
      if (i >= 64 && i <= 79) return model_str[8*(i-64)+:8];
      if (i >= 88 && i <= 105) return disc_id[8*(i-88)+:8];
      return 8'h00;
    end
    if (p[14:11] != 4'h1) return 8'h00;
    case (i)
      1: return 8'h01;
      2: return disc_state;
      22: return 8'h01;
      23: return app_code;
      24: return phys_code;
      30: return 8'h02;
      31: return power_tuning_code;
      32: return wavelength_code;
      38: return 8'h03;
      46: return 8'h04;
      54: return 8'h05;
      default: ;
    endcase
    if (i >= 4 && i <= 21) return disc_id[8*(i-4)+:8];
    if (i >= 25 && i <= 27) return last_data_addr[8*(27-i)+:8];
    if (i >= 33 && i <= 36) return strategy_code[8*(36-i)+:8];
    if (i >= 39 && i <= 44) return maker_seg[8*(i-39)+:8];
    if (i >= 47 && i <= 52) return maker_seg[8*(i-41)+:8];
    if (i >= 55 && i <= 60) return maker_seg[8*(i-43)+:8];
    return 8'h00;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // read data stand only in the cycle after the strobe
    @(posedge clk);
    chk("register read", e, reg_rdata);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // stream monitor: every accepted byte against the expected layout
  always @(posedge clk) begin
    if (chk_on && hold_q) chk("held position", 32'(held_pos), 32'(byte_position));
    if (chk_on && out_valid === 1'b1 && out_ready === 1'b1) begin
      chk("position", 32'(exp_pos), 32'(byte_position));
      chk("byte", 32'(exp_byte(exp_pos)), 32'(out_byte));
      chk("block", 32'(exp_pos[15] ? tgt + 24'h1 : tgt), 32'(out_block));
      chk("last", 32'(exp_pos == 16'hffff), 32'(out_last));
      exp_pos <= exp_pos + 16'h1;
      n_hs++;
    end
    if (chk_on && region_done === 1'b1) n_done++;
    if (resetn !== 1'b1) begin
      exp_pos <= 16'h0;
      n_hs = 0;
    end
    hold_q <= out_valid === 1'b1 && out_ready === 1'b0;
    held_pos <= byte_position;
  end

  initial begin
    clk = 0; resetn = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
    stall_en = 0; chk_on = 0; rnd = 32'd91817;
    for (w = 0; w < 8; w++) maker_str[32*w+:32] = next_rnd();
    {serial_str, model_str} = {next_rnd(), next_rnd(), next_rnd(), next_rnd(),
      next_rnd(), next_rnd(), next_rnd(), next_rnd()};
    disc_id = 144'({next_rnd(), next_rnd(), next_rnd(), next_rnd(), next_rnd()});
    maker_seg = 144'({next_rnd(), next_rnd(), next_rnd(), next_rnd(), next_rnd()});
    {app_code, phys_code} = 16'(next_rnd());
    last_data_addr = 24'(next_rnd());
    {power_tuning_code, wavelength_code} = 16'(next_rnd());
    strategy_code = next_rnd();
    disc_state = 8'h04;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd(REG_TARGET, 32'h0000223c);
    rd(REG_STATUS, 32'h0);
    rd(REG_CTRL, 32'h0);
    rd(8'h10, 32'h0);
    $display("test reset values done");
    // start refused outside the window and with an illegal disc state
    wr(REG_TARGET, 32'h000024f8);
    disc_state <= 8'(next_rnd()) & 8'h03;
    wr(REG_CTRL, 32'h1);
    rd(REG_STATUS, 32'h4);
    chk("valid", 32'h0, 32'(out_valid));
    wr(REG_STATUS, 32'h4);
    disc_state <= 8'h04;
    wr(REG_TARGET, 32'h0000223c);
    wr(REG_CTRL, 32'h1);
    rd(REG_STATUS, 32'h4);
    wr(REG_STATUS, 32'h4);
    rd(REG_STATUS, 32'h0);
    $display("test refusals done");
    // partial run, then reset in mid-stream; inputs settle before start
    disc_state <= 8'(next_rnd()) & 8'h03;
    tgt = 24'h00223c;
    chk_on <= 1'b1;
    wr(REG_CTRL, 32'h1);
    repeat (100) @(posedge clk);
    chk_on <= 1'b0;
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset valid", 32'h0, 32'(out_valid));
    chk("reset position", 32'h0, 32'(byte_position));
    resetn <= 1'b1;
    $display("test mid-run reset done");
    // full region with stalls, a restart attempt and a target write while busy
    tgt = 24'h00223c + 24'(next_rnd() % 700);
    wr(REG_TARGET, 32'(tgt));
    stall_en <= 1'b1;
    chk_on <= 1'b1;
    wr(REG_CTRL, 32'h1);
    repeat (50) @(posedge clk);
    wr(REG_CTRL, 32'h1);
    wr(REG_TARGET, 32'h0000223c);
    rd(REG_TARGET, 32'(tgt));
    w = 0;
    while (region_done !== 1'b1 && w < 90000) begin
      @(posedge clk);
      w++;
    end
    if (w >= 90000) begin
      n_mismatch++;
      $display("[ERR] region done expected 1 seen 0");
      stop_test();
    end
    repeat (2) @(posedge clk);
    chk("handshakes", 32'd65536, 32'(n_hs));
    chk("done pulses", 32'd1, 32'(n_done));
    chk("valid after", 32'h0, 32'(out_valid));
    rd(REG_STATUS, 32'h2);
    wr(REG_STATUS, 32'h2);
    rd(REG_STATUS, 32'h0);
    $display("test full region done");
    stop_test();
  end
endmodule

// ==== common/rm_sector_pkg.sv ====
package rm_sector_pkg;
  // placement window in error-correction block addresses
  localparam logic [23:0] REGION_FIRST_BLOCK = 24'h00223c;
  localparam logic [23:0] REGION_LAST_BLOCK = 24'h0024f8;
  // region geometry
  localparam int POS_W = 16;
  localparam logic [15:0] REGION_LAST_POS = 16'hffff;
  localparam logic [15:0] RESERVED_BYTES = 16'h4000;
  localparam logic [15:0] RECORD_BASE = 16'h8000;
  localparam logic [15:0] UNIT_BYTES = 16'h0800;
  localparam logic [3:0] FIELD0_SECTOR = 4'h1;
  // identity unit layout
  localparam logic [10:0] MAKER_FIRST = 11'h000;
  localparam logic [10:0] MAKER_LAST = 11'h01f;
  localparam logic [10:0] SERIAL_FIRST = 11'h028;
  localparam logic [10:0] SERIAL_LAST = 11'h037;
  localparam logic [10:0] MODEL_FIRST = 11'h040;
  localparam logic [10:0] MODEL_LAST = 11'h04f;
  localparam logic [10:0] UDISC_FIRST = 11'h058;
  localparam logic [10:0] UDISC_LAST = 11'h069;
  // management field 0 layout
  localparam logic [10:0] F0_FMT_HI = 11'h000;
  localparam logic [10:0] F0_FMT_LO = 11'h001;
  localparam logic [10:0] F0_STATE = 11'h002;
  localparam logic [10:0] F0_DISC_FIRST = 11'h004;
  localparam logic [10:0] F0_DISC_LAST = 11'h015;
  localparam logic [10:0] PP_ID1 = 11'h016;
  localparam logic [10:0] PP_APP = 11'h017;
  localparam logic [10:0] PP_PHYS = 11'h018;
  localparam logic [10:0] PP_ADDR_FIRST = 11'h019;
  localparam logic [10:0] PP_ADDR_LAST = 11'h01b;
  localparam logic [10:0] PP_ID2 = 11'h01e;
  localparam logic [10:0] PP_POWER = 11'h01f;
  localparam logic [10:0] PP_WAVE = 11'h020;
  localparam logic [10:0] PP_STRAT_FIRST = 11'h021;
  localparam logic [10:0] PP_STRAT_LAST = 11'h024;
  localparam logic [10:0] PP_ID3 = 11'h026;
  localparam logic [10:0] PP_SEG3_FIRST = 11'h027;
  localparam logic [10:0] PP_SEG3_LAST = 11'h02c;
  localparam logic [10:0] PP_ID4 = 11'h02e;
  localparam logic [10:0] PP_SEG4_FIRST = 11'h02f;
  localparam logic [10:0] PP_SEG4_LAST = 11'h034;
  localparam logic [10:0] PP_ID5 = 11'h036;
  localparam logic [10:0] PP_SEG5_FIRST = 11'h037;
  localparam logic [10:0] PP_SEG5_LAST = 11'h03c;
  localparam logic [15:0] FORMAT_WORD = 16'h0001;
  localparam logic [7:0] FIELD_ID1 = 8'h01;
  localparam logic [7:0] FIELD_ID2 = 8'h02;
  localparam logic [7:0] FIELD_ID3 = 8'h03;
  localparam logic [7:0] FIELD_ID4 = 8'h04;
  localparam logic [7:0] FIELD_ID5 = 8'h05;
  // disc state codes
  typedef enum logic [7:0] {
    DISC_EMPTY = 8'h00,
    DISC_SINGLE_PASS = 8'h01,
    DISC_INCREMENTAL = 8'h02,
    DISC_FINALIZED = 8'h03
  } disc_state_e;
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TARGET = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_POSITION = 8'h0c;
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam logic [23:0] TARGET_RESET = 24'h00223c;
endpackage

// ==== verilog/recording_mgmt_sector_builder.sv ====
// Summary of operation
// - emit only within blocks 00223C to 0024F8
// - 32768-byte lead-in precedes the management record
// - system reserved lead-in bytes are zero
// - eight identical 2048-byte identity units
// - identity unit field layout, gaps zero
// - identity strings copied unaltered, meaning ignored
// - record is sixteen sectors, sector order
// - sector 0 linking loss, then fields 0-14
// - each field exactly 2048 bytes of data
// - reserve 2048-byte linking loss sector first
// - field 0 layout, bytes 86-2047 zero
// - format word always 0001
// - disc state codes 00 to 03
// - never write disc state above 03
// - bytes 22-85 hold pre-pit copy
// - pre-pit group one layout
// - pre-pit group two layout
// - three maker segments with ids 03-05
// - maker segment bytes passed through untouched
module recording_mgmt_sector_builder
  import rm_sector_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [255:0] maker_str,
  input wire logic [127:0] serial_str,
  input wire logic [127:0] model_str,
  input wire logic [143:0] disc_id,
  input wire logic [7:0] disc_state,
  input wire logic [7:0] app_code,
  input wire logic [7:0] phys_code,
  input wire logic [23:0] last_data_addr,
  input wire logic [7:0] power_tuning_code,
  input wire logic [7:0] wavelength_code,
  input wire logic [31:0] strategy_code,
  input wire logic [143:0] maker_seg,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_byte,
  output logic [15:0] byte_position,
  output logic [23:0] out_block,
  output logic out_last,
  output logic region_done
);

  typedef enum logic {IDLE, RUN} run_state_e;

  run_state_e state_q;
  logic [15:0] pos_q;
  logic [7:0] byte_q;
  logic [23:0] block_q;
  logic [23:0] target_q;
  logic done_q;
  logic refused_q;
  logic done_pulse_q;
  logic [31:0] rdata_q;
  logic hs;
  logic last_hs;
  logic start_req;
  logic target_ok;
  logic state_ok;
  logic start_ok;
  logic clr_done;
  logic clr_refused;
  logic [15:0] pos_d;

  // identity unit content, repeated for every unit
  function automatic logic [7:0] unit_byte(input logic [10:0] o);
    logic [10:0] idx;
    idx = 11'h000;
    unit_byte = 8'h00;
    if (o <= MAKER_LAST) begin
      idx = o - MAKER_FIRST;
      unit_byte = maker_str[{idx[4:0], 3'b000} +: 8];
    end else if (o >= SERIAL_FIRST && o <= SERIAL_LAST) begin
      idx = o - SERIAL_FIRST;
      unit_byte = serial_str[{idx[3:0], 3'b000} +: 8];
    end else if (o >= MODEL_FIRST && o <= MODEL_LAST) begin
      idx = o - MODEL_FIRST;
      unit_byte = model_str[{idx[3:0], 3'b000} +: 8];
    end else if (o >= UDISC_FIRST && o <= UDISC_LAST) begin
      idx = o - UDISC_FIRST;
      unit_byte = disc_id[{idx[4:0], 3'b000} +: 8];
    end
  endfunction

  // management field 0 content; all bytes past the pre-pit copy are zero
  function automatic logic [7:0] field0_byte(input logic [10:0] o);
    logic [10:0] idx;
    idx = 11'h000;
    field0_byte = 8'h00;
    if (o == F0_FMT_HI) begin
      field0_byte = FORMAT_WORD[15:8];
    end else if (o == F0_FMT_LO) begin
      field0_byte = FORMAT_WORD[7:0];
    end else if (o == F0_STATE) begin
      field0_byte = (disc_state <= DISC_FINALIZED) ? disc_state : DISC_EMPTY;
    end else if (o >= F0_DISC_FIRST && o <= F0_DISC_LAST) begin
      idx = o - F0_DISC_FIRST;
      field0_byte = disc_id[{idx[4:0], 3'b000} +: 8];
    end else if (o == PP_ID1) begin
      field0_byte = FIELD_ID1;
    end else if (o == PP_APP) begin
      field0_byte = app_code;
    end else if (o == PP_PHYS) begin
      field0_byte = phys_code;
    end else if (o >= PP_ADDR_FIRST && o <= PP_ADDR_LAST) begin
      idx = PP_ADDR_LAST - o;
      field0_byte = last_data_addr[{idx[1:0], 3'b000} +: 8];
    end else if (o == PP_ID2) begin
      field0_byte = FIELD_ID2;
    end else if (o == PP_POWER) begin
      field0_byte = power_tuning_code;
    end else if (o == PP_WAVE) begin
      field0_byte = wavelength_code;
    end else if (o >= PP_STRAT_FIRST && o <= PP_STRAT_LAST) begin
      idx = PP_STRAT_LAST - o;
      field0_byte = strategy_code[{idx[1:0], 3'b000} +: 8];
    end else if (o == PP_ID3) begin
      field0_byte = FIELD_ID3;
    end else if (o >= PP_SEG3_FIRST && o <= PP_SEG3_LAST) begin
      idx = o - PP_SEG3_FIRST;
      field0_byte = maker_seg[{idx[4:0], 3'b000} +: 8];
    end else if (o == PP_ID4) begin
      field0_byte = FIELD_ID4;
    end else if (o >= PP_SEG4_FIRST && o <= PP_SEG4_LAST) begin
      idx = o - PP_SEG4_FIRST + 11'd6;
      field0_byte = maker_seg[{idx[4:0], 3'b000} +: 8];
    end else if (o == PP_ID5) begin
      field0_byte = FIELD_ID5;
    end else if (o >= PP_SEG5_FIRST && o <= PP_SEG5_LAST) begin
      idx = o - PP_SEG5_FIRST + 11'd12;
      field0_byte = maker_seg[{idx[4:0], 3'b000} +: 8];
    end
  endfunction

  // byte at a region position: lead-in first, then the sixteen record sectors
  function automatic logic [7:0] region_byte(input logic [15:0] p);
    region_byte = 8'h00;
    if (!p[15]) begin
      if (p[14]) begin
        region_byte = unit_byte(p[10:0]);
      end
    end else if (p[14:11] == FIELD0_SECTOR) begin
      region_byte = field0_byte(p[10:0]);
    end
  endfunction

  // handshake and start qualification
  assign hs = out_valid && out_ready;
  assign last_hs = hs && (pos_q == REGION_LAST_POS);
  assign start_req = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_START_BIT];
  assign target_ok = (target_q >= REGION_FIRST_BLOCK)
                     && (target_q < REGION_LAST_BLOCK);
  assign state_ok = (disc_state <= DISC_FINALIZED);
  assign start_ok = start_req && (state_q == IDLE) && target_ok && state_ok;
  assign clr_done = reg_wr && (reg_addr == REG_STATUS) && reg_wdata[STAT_DONE_BIT];
  assign clr_refused = reg_wr && (reg_addr == REG_STATUS) && reg_wdata[STAT_REFUSED_BIT];
  assign pos_d = start_ok ? 16'h0000 : pos_q + 16'h0001;

  // run control
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= IDLE;
    end else if (start_ok) begin
      state_q <= RUN;
    end else if (last_hs) begin
      state_q <= IDLE;
    end
  end

  // position and byte load on start and advance only on handshake
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pos_q <= 16'h0000;
      byte_q <= 8'h00;
      block_q <= TARGET_RESET;
    end else if (start_ok || (hs && !last_hs)) begin
      pos_q <= pos_d;
      byte_q <= region_byte(pos_d);
      // record half sits one block past the lead-in
      block_q <= target_q + {23'h0, pos_d[15]};
    end
  end

  // target block, writable only while idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      target_q <= TARGET_RESET;
    end else if (reg_wr && (reg_addr == REG_TARGET) && (state_q == IDLE)) begin
      target_q <= reg_wdata[23:0];
    end
  end

  // sticky status, set beats clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
      done_pulse_q <= 1'b0;
    end else begin
      done_pulse_q <= last_hs;
      if (last_hs) begin
        done_q <= 1'b1;
      end else if (clr_done) begin
        done_q <= 1'b0;
      end
      if (start_req && (state_q == IDLE) && !(target_ok && state_ok)) begin
        refused_q <= 1'b1;
      end else if (clr_refused) begin
        refused_q <= 1'b0;
      end
    end
  end

  // register read, data one cycle after strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_TARGET: rdata_q <= {8'h00, target_q};
        REG_STATUS: rdata_q <= {29'h0, refused_q, done_q, state_q == RUN};
        REG_POSITION: rdata_q <= {16'h0000, pos_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // outputs
  assign reg_rdata = rdata_q;
  assign out_valid = (state_q == RUN);
  assign out_byte = byte_q;
  assign byte_position = pos_q;
  assign out_block = block_q;
  assign out_last = out_valid && (pos_q == REGION_LAST_POS);
  assign region_done = done_pulse_q;

  // checks
  sequence s_stall;
    out_valid && !out_ready;
  endsequence

  sequence s_accept;
    start_ok;
  endsequence

  property p_hold;
    @(posedge clk) disable iff (!resetn)
    s_stall |=> $stable(out_byte) && $stable(byte_position) && out_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("byte moved under stall");

  property p_step;
    @(posedge clk) disable iff (!resetn)
    hs && !out_last |=> out_valid && byte_position == $past(byte_position) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("position skipped");

  property p_start;
    @(posedge clk) disable iff (!resetn)
    s_accept |=> out_valid && byte_position == 16'h0000 && out_block == $past(target_q);
  endproperty
  a_start: assert property (p_start) else $error("start not at lead-in byte 0");

  property p_window;
    @(posedge clk) disable iff (!resetn)
    out_valid |-> out_block >= REGION_FIRST_BLOCK && out_block <= REGION_LAST_BLOCK;
  endproperty
  a_window: assert property (p_window) else $error("block outside region");

  property p_reserved;
    @(posedge clk) disable iff (!resetn)
    out_valid && byte_position < RESERVED_BYTES |-> out_byte == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved byte not zero");

  property p_maker;
    @(posedge clk) disable iff (!resetn)
    out_valid && byte_position[15:14] == 2'b01 && byte_position[10:5] == 6'h00
      |-> out_byte == maker_str[{byte_position[4:0], 3'b000} +: 8];
  endproperty
  a_maker: assert property (p_maker) else $error("maker byte wrong in unit");

  property p_unit_tail;
    @(posedge clk) disable iff (!resetn)
    out_valid && byte_position[15:14] == 2'b01 && byte_position[10:0] > UDISC_LAST
      |-> out_byte == 8'h00;
  endproperty
  a_unit_tail: assert property (p_unit_tail) else $error("unit tail not zero");

  property p_format;
    @(posedge clk) disable iff (!resetn)
    out_valid && byte_position == RECORD_BASE + UNIT_BYTES + 16'h0001
      |-> out_byte == FORMAT_WORD[7:0];
  endproperty
  a_format: assert property (p_format) else $error("format word low byte wrong");

  property p_state_code;
    @(posedge clk) disable iff (!resetn)
    out_valid && byte_position == RECORD_BASE + UNIT_BYTES + 16'h0002
      |-> out_byte <= DISC_FINALIZED;
  endproperty
  a_state_code: assert property (p_state_code) else $error("disc state out of range");

  property p_linking;
    @(posedge clk) disable iff (!resetn)
    out_valid && byte_position[15:11] == 5'h10 |-> out_byte == 8'h00;
  endproperty
  a_linking: assert property (p_linking) else $error("linking loss sector not zero");

  property p_end;
    @(posedge clk) disable iff (!resetn)
    hs && out_last |=> !out_valid && region_done ##1 !region_done;
  endproperty
  a_end: assert property (p_end) else $error("region end not signalled");

  property p_unit_gap;
    @(posedge clk) disable iff (!resetn)
    out_valid && byte_position[15:14] == 2'b01 && byte_position[10:0] > MAKER_LAST
      && byte_position[10:0] < SERIAL_FIRST |-> out_byte == 8'h00;
  endproperty
  a_unit_gap: assert property (p_unit_gap) else $error("unit gap not zero");

  property p_field_id;
    @(posedge clk) disable iff (!resetn)
    out_valid && byte_position == RECORD_BASE + UNIT_BYTES + {5'h00, PP_ID1}
      |-> out_byte == FIELD_ID1;
  endproperty
  a_field_id: assert property (p_field_id) else $error("pre-pit copy id wrong");

  property p_field0_tail;
    @(posedge clk) disable iff (!resetn)
    out_valid && byte_position[15:11] == {1'b1, FIELD0_SECTOR}
      && byte_position[10:0] > PP_SEG5_LAST |-> out_byte == 8'h00;
  endproperty
  a_field0_tail: assert property (p_field0_tail) else $error("field 0 tail not zero");

  property p_later_fields;
    @(posedge clk) disable iff (!resetn)
    out_valid && byte_position[15] && byte_position[14:11] > FIELD0_SECTOR
      |-> out_byte == 8'h00;
  endproperty
  a_later_fields: assert property (p_later_fields) else $error("later field not zero");

  // last byte of a sector hands over to byte 0 of the next one
  sequence s_sector_end;
    hs && (&byte_position[10:0]) && !out_last;
  endsequence

  property p_sector_step;
    @(posedge clk) disable iff (!resetn)
    s_sector_end |=> byte_position[10:0] == 11'h000
      && byte_position[15:11] == $past(byte_position[15:11]) + 5'h01;
  endproperty
  a_sector_step: assert property (p_sector_step) else $error("sector length wrong");

endmodule
